/* rcp_clock_regs.v */
// Purpose: Reset cause flags, slow RC handshake, PLL and timer clock settings
// Assumes: AHB-Lite slave, zero wait states while clk_enable is high, hclk at 125 MHz
// Notes: Cause flags are reset only by power_resetn, which leaves bits 27 to 25 set, or cleared by the clear bit
//
// Functional notes
// - Low-power reset sets bit 31, held until software clears flags.
// - Window watchdog reset sets bit 30.
// - Independent watchdog reset sets bit 29.
// - Software reset sets bit 28.
// - Power-on or power-down reset sets bit 27.
// - External reset pin sets bit 26.
// - Power-on, power-down or brownout reset sets bit 25.
// - Writing one to bit 24 clears flags 31 to 25; zero does nothing.
// - Ready bit 1 high while slow oscillator is enabled and stable.
// - After enable clears, ready falls after three oscillator cycles.
// - Enable bit 0 switches the slow oscillator on and off.
// - PLL and dedicated registers take word, half, byte; wait states only while clk_enable is low.
// - Spread bit 31 enables main PLL modulation.
// - Spread bit 30 selects center (0) or down (1) spread.
// - Bits 27:13 set modulation amplitude, bits 12:0 its period.
// - Audio output divider 30:28 divides VCO; codes 0 and 1 invalid.
// - Audio multiplier 14:6 valid only from 50 to 432.
// - Byte writes never update the audio multiplier.
// - Multiplier and input divider writable only while audio PLL off.
// - Audio input divider 5:0 valid from 2 to 63.
// - Timer prescale select picks core, twice or four times bus clock.
`include "rcp_map.vh"
`timescale 1ns/1ps

module rcp_sync #(
  parameter WIDTH = 1
) (
  input wire hclk,
  input wire rst_n,
  input wire clk_enable,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1;

  always @(posedge hclk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else if (clk_enable) begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

module rcp_clock_regs (
  input wire hclk,
  input wire hresetn,
  input wire power_resetn,
  input wire clk_enable,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire low_power_reset_event,
  input wire window_dog_reset_event,
  input wire independent_dog_reset_event,
  input wire software_reset_event,
  input wire power_on_reset_event,
  input wire external_reset_pin_event,
  input wire brownout_reset_event,
  input wire slow_rc_clk,
  input wire slow_rc_stable,
  input wire audio_pll_enable,
  input wire [2:0] apb1_prescale,
  input wire [2:0] apb2_prescale,
  output reg slow_rc_enable,
  output reg slow_rc_ready,
  output reg low_power_reset_flag,
  output reg window_dog_reset_flag,
  output reg independent_dog_reset_flag,
  output reg software_reset_flag,
  output reg power_on_reset_flag,
  output reg pin_reset_flag,
  output reg brownout_reset_flag,
  output reg spread_enable,
  output reg spread_shape_select,
  output reg [14:0] modulation_step,
  output reg [12:0] modulation_period,
  output reg [2:0] audio_pll_out_divider,
  output reg [8:0] audio_pll_multiplier,
  output reg [5:0] audio_pll_in_divider,
  output reg audio_pll_config_valid,
  output reg timer_clock_prescale_select,
  output reg [1:0] apb1_timer_clock_sel,
  output reg [1:0] apb2_timer_clock_sel
);

  // Synchronised pin inputs
  wire [6:0] event_sync;
  wire [2:0] osc_sync;
  wire slow_rc_clk_s;
  wire slow_rc_stable_s;
  wire audio_pll_enable_s;

  rcp_sync #(.WIDTH(7)) u_event_sync (
    .hclk(hclk),
    .rst_n(power_resetn),
    .clk_enable(clk_enable),
    .async_in({low_power_reset_event, window_dog_reset_event,
               independent_dog_reset_event, software_reset_event,
               power_on_reset_event, external_reset_pin_event,
               brownout_reset_event}),
    .sync_out(event_sync)
  );

  rcp_sync #(.WIDTH(3)) u_osc_sync (
    .hclk(hclk),
    .rst_n(hresetn),
    .clk_enable(clk_enable),
    .async_in({slow_rc_clk, slow_rc_stable, audio_pll_enable}),
    .sync_out(osc_sync)
  );

  assign slow_rc_clk_s = osc_sync[2];
  assign slow_rc_stable_s = osc_sync[1];
  assign audio_pll_enable_s = osc_sync[0];

  // Byte lanes touched by an access
  function [3:0] lanes;
    input [2:0] size;
    input [1:0] low;
    begin
      case (size)
        3'h0: lanes = 4'h1 << low;
        3'h1: lanes = low[1] ? 4'hc : 4'h3;
        default: lanes = 4'hf;
      endcase
    end
  endfunction

  // Timer clock multiple for one bus prescaler
  function [1:0] timer_sel;
    input [2:0] pre;
    input sel;
    begin
      if (!sel) begin
        timer_sel = pre[2] ? `RCP_TSEL_X2 : `RCP_TSEL_CORE;
      end else if (!pre[2] || pre == `RCP_PRE_DIV2) begin
        timer_sel = `RCP_TSEL_CORE;
      end else begin
        timer_sel = `RCP_TSEL_X4;
      end
    end
  endfunction

  // Bus address and data phases
  reg dp_valid;
  reg dp_write;
  reg [`RCP_ADDR_W-1:0] dp_addr;
  reg [2:0] dp_size;
  wire accept;
  wire wr_now;
  wire [3:0] wr_lanes;
  wire [31:0] wr_bits;

  assign hreadyout = clk_enable;
  assign hresp = 1'b0;
  assign accept = hsel & htrans[1] & hready & clk_enable;
  assign wr_now = dp_valid & dp_write & clk_enable;
  assign wr_lanes = lanes(dp_size, dp_addr[1:0]);
  assign wr_bits = {{8{wr_lanes[3]}}, {8{wr_lanes[2]}},
                    {8{wr_lanes[1]}}, {8{wr_lanes[0]}}};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= {`RCP_ADDR_W{1'b0}};
      dp_size <= 3'h0;
    end else if (clk_enable) begin
      dp_valid <= accept;
      if (accept) begin
        dp_write <= hwrite;
        dp_addr <= haddr[`RCP_ADDR_W-1:0];
        dp_size <= hsize;
      end
    end
  end

  wire wr_cause = wr_now && {dp_addr[`RCP_ADDR_W-1:2], 2'h0} == `RCP_OFS_CAUSE;
  wire wr_spread = wr_now && {dp_addr[`RCP_ADDR_W-1:2], 2'h0} == `RCP_OFS_SPREAD;
  wire wr_audio = wr_now && {dp_addr[`RCP_ADDR_W-1:2], 2'h0} == `RCP_OFS_AUDIO;
  wire wr_dck = wr_now && {dp_addr[`RCP_ADDR_W-1:2], 2'h0} == `RCP_OFS_DCK;

  // Reset cause flags, power reset domain
  wire [6:0] flags;
  reg [6:0] next_flags;
  wire clear_reset_flags;

  assign flags = {low_power_reset_flag, window_dog_reset_flag,
                  independent_dog_reset_flag, software_reset_flag,
                  power_on_reset_flag, pin_reset_flag, brownout_reset_flag};
  assign clear_reset_flags = wr_cause & wr_lanes[3] & hwdata[`RCP_BIT_CLR];

  always @* begin
    next_flags = flags;
    if (clear_reset_flags) begin
      next_flags = 7'h00;
    end
    // Set wins over a clear in the same cycle
    next_flags[6] = next_flags[6] | event_sync[6];
    next_flags[5] = next_flags[5] | event_sync[5];
    next_flags[4] = next_flags[4] | event_sync[4];
    next_flags[3] = next_flags[3] | event_sync[3];
    next_flags[2] = next_flags[2] | event_sync[2];
    next_flags[1] = next_flags[1] | event_sync[1];
    next_flags[0] = next_flags[0] | event_sync[0] | event_sync[2];
  end

  always @(posedge hclk or negedge power_resetn) begin
    if (!power_resetn) begin
      {low_power_reset_flag, window_dog_reset_flag,
       independent_dog_reset_flag, software_reset_flag,
       power_on_reset_flag, pin_reset_flag,
       brownout_reset_flag} <= `RCP_FLAGS_RST;
    end else if (clk_enable) begin
      {low_power_reset_flag, window_dog_reset_flag,
       independent_dog_reset_flag, software_reset_flag,
       power_on_reset_flag, pin_reset_flag,
       brownout_reset_flag} <= next_flags;
    end
  end

  // Slow RC oscillator enable and ready
  reg next_slow_rc_enable;
  reg next_slow_rc_ready;
  reg slow_rc_clk_d;
  reg [1:0] fall_count;
  reg [1:0] next_fall_count;
  wire osc_rise;

  assign osc_rise = slow_rc_clk_s & ~slow_rc_clk_d;

  always @* begin
    next_slow_rc_enable = slow_rc_enable;
    if (wr_cause && wr_lanes[0]) begin
      next_slow_rc_enable = hwdata[`RCP_BIT_EN];
    end
  end

  always @* begin
    next_slow_rc_ready = slow_rc_ready;
    next_fall_count = 2'h0;
    if (slow_rc_enable) begin
      next_slow_rc_ready = slow_rc_stable_s;
    end else if (slow_rc_ready) begin
      next_fall_count = fall_count;
      if (osc_rise) begin
        if (fall_count == `RCP_SLOW_RC_FALL - 2'h1) begin
          next_slow_rc_ready = 1'b0;
          next_fall_count = 2'h0;
        end else begin
          next_fall_count = fall_count + 2'h1;
        end
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slow_rc_enable <= 1'b0;
      slow_rc_ready <= 1'b0;
      slow_rc_clk_d <= 1'b0;
      fall_count <= 2'h0;
    end else if (clk_enable) begin
      slow_rc_enable <= next_slow_rc_enable;
      slow_rc_ready <= next_slow_rc_ready;
      slow_rc_clk_d <= slow_rc_clk_s;
      fall_count <= next_fall_count;
    end
  end

  // Spread spectrum, audio PLL and dedicated clock registers
  reg [31:0] spread_reg;
  reg [31:0] audio_reg;
  reg [31:0] dck_reg;
  reg [31:0] next_spread;
  reg [31:0] next_audio;
  reg [31:0] next_dck;
  reg [31:0] audio_mask;

  always @* begin
    next_spread = spread_reg;
    if (wr_spread) begin
      next_spread = (spread_reg & ~(wr_bits & `RCP_SPREAD_WMASK)) |
                    (hwdata & wr_bits & `RCP_SPREAD_WMASK);
    end
  end

  always @* begin
    audio_mask = wr_bits & `RCP_AUDIO_WMASK;
    if (dp_size == 3'h0) begin
      audio_mask[`RCP_MUL_HI:`RCP_MUL_LO] = 9'h000;
    end
    if (audio_pll_enable_s) begin
      audio_mask[`RCP_MUL_HI:`RCP_MUL_LO] = 9'h000;
      audio_mask[`RCP_IDIV_HI:`RCP_IDIV_LO] = 6'h00;
    end
    next_audio = audio_reg;
    if (wr_audio) begin
      next_audio = (audio_reg & ~audio_mask) | (hwdata & audio_mask);
    end
  end

  always @* begin
    next_dck = dck_reg;
    if (wr_dck) begin
      next_dck = (dck_reg & ~(wr_bits & `RCP_DCK_WMASK)) |
                 (hwdata & wr_bits & `RCP_DCK_WMASK);
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      spread_reg <= `RCP_RST_SPREAD;
      audio_reg <= `RCP_RST_AUDIO;
      dck_reg <= `RCP_RST_DCK;
    end else if (clk_enable) begin
      spread_reg <= next_spread;
      audio_reg <= next_audio;
      dck_reg <= next_dck;
    end
  end

  // Field outputs, registered from next values at the same edge as the register
  wire [2:0] odiv_n = next_audio[`RCP_ODIV_HI:`RCP_ODIV_LO];
  wire [8:0] mul_n = next_audio[`RCP_MUL_HI:`RCP_MUL_LO];
  wire [5:0] idiv_n = next_audio[`RCP_IDIV_HI:`RCP_IDIV_LO];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      spread_enable <= 1'b0;
      spread_shape_select <= 1'b0;
      modulation_step <= 15'h0000;
      modulation_period <= 13'h0000;
      audio_pll_out_divider <= 3'h0;
      audio_pll_multiplier <= 9'h000;
      audio_pll_in_divider <= 6'h00;
      audio_pll_config_valid <= 1'b0;
      timer_clock_prescale_select <= 1'b0;
      apb1_timer_clock_sel <= `RCP_TSEL_CORE;
      apb2_timer_clock_sel <= `RCP_TSEL_CORE;
    end else if (clk_enable) begin
      spread_enable <= next_spread[`RCP_BIT_SSEN];
      spread_shape_select <= next_spread[`RCP_BIT_SHAPE];
      modulation_step <= next_spread[`RCP_STEP_HI:`RCP_STEP_LO];
      modulation_period <= next_spread[`RCP_PER_HI:`RCP_PER_LO];
      audio_pll_out_divider <= odiv_n;
      audio_pll_multiplier <= mul_n;
      audio_pll_in_divider <= idiv_n;
      audio_pll_config_valid <= (odiv_n >= `RCP_ODIV_MIN) &&
                                (mul_n >= `RCP_MUL_MIN) &&
                                (mul_n <= `RCP_MUL_MAX) &&
                                (idiv_n >= `RCP_IDIV_MIN);
      timer_clock_prescale_select <= next_dck[`RCP_BIT_TIMER_CLOCK_PRESCALE_SELECT];
      apb1_timer_clock_sel <= timer_sel(apb1_prescale,
                                        next_dck[`RCP_BIT_TIMER_CLOCK_PRESCALE_SELECT]);
      apb2_timer_clock_sel <= timer_sel(apb2_prescale,
                                        next_dck[`RCP_BIT_TIMER_CLOCK_PRESCALE_SELECT]);
    end
  end

  // Read data from the values the registers take at this edge
  reg [31:0] rd_value;
  wire [31:0] cause_value;

  assign cause_value = {next_flags, 1'b0, 22'h000000,
                        next_slow_rc_ready, next_slow_rc_enable};

  always @* begin
    case ({haddr[`RCP_ADDR_W-1:2], 2'h0})
      `RCP_OFS_CAUSE: rd_value = cause_value;
      `RCP_OFS_SPREAD: rd_value = next_spread;
      `RCP_OFS_AUDIO: rd_value = next_audio | `RCP_AUDIO_RSVD;
      `RCP_OFS_DCK: rd_value = next_dck;
      default: rd_value = 32'h00000000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (clk_enable) begin
      if (accept && !hwrite) begin
        hrdata <= rd_value;
      end
    end
  end

endmodule

/* rcp_map.vh */
// Purpose: Offsets, fields, reset values and counts of the clock regs
// Assumes: Byte addresses on a 32-bit AHB-Lite bus
// Notes: Definitions only
`ifndef RCP_MAP_VH
`define RCP_MAP_VH

`define RCP_ADDR_W 8
`define RCP_OFS_CAUSE 8'h74
`define RCP_OFS_SPREAD 8'h80
`define RCP_OFS_AUDIO 8'h84
`define RCP_OFS_DCK 8'h8c

`define RCP_RST_CAUSE 32'h0e000000
`define RCP_RST_SPREAD 32'h00000000
`define RCP_RST_AUDIO 32'h24003000
`define RCP_RST_DCK 32'h00000000

`define RCP_BIT_LP 31
`define RCP_BIT_WWD 30
`define RCP_BIT_IWD 29
`define RCP_BIT_SW 28
`define RCP_BIT_POR 27
`define RCP_BIT_PIN 26
`define RCP_BIT_BOR 25
`define RCP_BIT_CLR 24
`define RCP_BIT_RDY 1
`define RCP_BIT_EN 0
`define RCP_FLAGS_RST 7'h07

`define RCP_BIT_SSEN 31
`define RCP_BIT_SHAPE 30
`define RCP_STEP_HI 27
`define RCP_STEP_LO 13
`define RCP_PER_HI 12
`define RCP_PER_LO 0

`define RCP_ODIV_HI 30
`define RCP_ODIV_LO 28
`define RCP_MUL_HI 14
`define RCP_MUL_LO 6
`define RCP_IDIV_HI 5
`define RCP_IDIV_LO 0
`define RCP_AUDIO_RSVD 32'h04000000

`define RCP_BIT_TIMER_CLOCK_PRESCALE_SELECT 24

`define RCP_SPREAD_WMASK 32'hcfffffff
`define RCP_AUDIO_WMASK 32'h70007fff
`define RCP_DCK_WMASK 32'h01000000

`define RCP_ODIV_MIN 3'h2
`define RCP_MUL_MIN 9'h032
`define RCP_MUL_MAX 9'h1b0
`define RCP_IDIV_MIN 6'h02

`define RCP_SLOW_RC_FALL 2'h3

`define RCP_TSEL_CORE 2'h0
`define RCP_TSEL_X2 2'h1
`define RCP_TSEL_X4 2'h2
`define RCP_PRE_DIV2 3'h4

`endif

/* rcp_clock_regs_checker.sv */
// Purpose: Port assertions for the clock register block
// Assumes: One clock domain, hclk; both resets active low
// Notes: Bind statement at the file foot
`timescale 1ns/1ps
module rcp_checker (
  input wire hclk,
  input wire hresetn,
  input wire power_resetn,
  input wire clk_enable,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [2:0] apb1_prescale,
  input wire window_dog_reset_event,
  input wire window_dog_reset_flag,
  input wire software_reset_flag,
  input wire power_on_reset_flag,
  input wire brownout_reset_flag,
  input wire slow_rc_stable,
  input wire slow_rc_enable,
  input wire slow_rc_ready,
  input wire [2:0] audio_pll_out_divider,
  input wire [8:0] audio_pll_multiplier,
  input wire [5:0] audio_pll_in_divider,
  input wire audio_pll_config_valid,
  input wire timer_clock_prescale_select,
  input wire [1:0] apb1_timer_clock_sel
);
  reg cause_dp;
  wire clr_fire = cause_dp & hwdata[24];
  // Data phase of a write to the cause register
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
      cause_dp <= 1'b0;
    else if (clk_enable)
      cause_dp <= hsel & htrans[1] & hready & hwrite & (haddr[7:2] == 6'h1d);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn || !power_resetn);
  chk_bus_okay: assert property (hresp == 1'b0)
    else $error("hresp not OKAY");
  chk_zero_wait: assert property (clk_enable |-> hreadyout)
    else $error("wait state inserted");
  chk_wdog_cause: assert property ($rose(window_dog_reset_flag) |->
    $past(window_dog_reset_event, 2) || $past(window_dog_reset_event, 3)
    || $past(window_dog_reset_event, 4)) else $error("flag set without event");
  chk_por_brown: assert property ($rose(power_on_reset_flag) |-> brownout_reset_flag)
    else $error("brownout flag missing on power-on");
  chk_flag_clear: assert property ($fell(software_reset_flag) |-> $past(clr_fire))
    else $error("flag cleared without clear write");
  chk_rdy_hold: assert property ($fell(slow_rc_enable) && slow_rc_ready |=>
    slow_rc_ready [*8] ##[1:60] !slow_rc_ready) else $error("ready fall timing");
  chk_rdy_rise: assert property ($rose(slow_rc_ready) |->
    $past(slow_rc_enable) && $past(slow_rc_stable, 3)) else $error("ready rose while off");
  chk_cfg_valid: assert property (audio_pll_config_valid ==
    (audio_pll_out_divider >= 3'h2 && audio_pll_multiplier >= 9'h032 &&
    audio_pll_multiplier <= 9'h1b0 && audio_pll_in_divider >= 6'h02))
    else $error("audio config valid wrong");
  chk_tim_sel: assert property ($past(clk_enable) && $past(hresetn) |->
    apb1_timer_clock_sel == (($past(apb1_prescale) < 3'h4 || (timer_clock_prescale_select
    && $past(apb1_prescale) == 3'h4)) ? 2'h0 : (timer_clock_prescale_select ? 2'h2 : 2'h1)))
    else $error("timer clock select wrong");
endmodule

bind rcp_clock_regs rcp_checker u_rcp_checker (.hclk, .hresetn, .power_resetn, .clk_enable,
  .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .apb1_prescale,
  .window_dog_reset_event, .window_dog_reset_flag, .software_reset_flag, .power_on_reset_flag,
  .brownout_reset_flag, .slow_rc_stable, .slow_rc_enable, .slow_rc_ready,
  .audio_pll_out_divider, .audio_pll_multiplier, .audio_pll_in_divider,
  .audio_pll_config_valid, .timer_clock_prescale_select, .apb1_timer_clock_sel);

/* rcp_tb.sv */
// Purpose: Self-checking bench for the clock register block
// Assumes: AHB-Lite single transfers, hclk at 125 MHz
// Notes: Slow oscillator clock runs free with a 74 ns period
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
  check_count = check_count + 1; \
  if ((g) !== (e)) begin \
    n_fail = n_fail + 1; \
    $display("[FAIL] %s expected %h seen %h", n, e, g); \
  end \
end
module testbench;
  reg hclk, hresetn, power_resetn, clk_enable, hsel, hwrite;
  reg slow_rc_clk, slow_rc_stable, audio_pll_enable;
  reg [31:0] haddr, hwdata, q;
  reg [1:0] htrans;
  reg [2:0] hsize, apb1_prescale, apb2_prescale;
  reg [6:0] ev;
  wire hreadyout, hresp, slow_rc_enable, slow_rc_ready, spread_enable, spread_shape_select;
  wire low_power_reset_flag, window_dog_reset_flag, independent_dog_reset_flag;
  wire software_reset_flag, power_on_reset_flag, pin_reset_flag, brownout_reset_flag;
  wire audio_pll_config_valid, timer_clock_prescale_select;
  wire [31:0] hrdata;
  wire [14:0] modulation_step;
  wire [12:0] modulation_period;
  wire [2:0] audio_pll_out_divider;
  wire [8:0] audio_pll_multiplier;
  wire [5:0] audio_pll_in_divider;
  wire [1:0] apb1_timer_clock_sel, apb2_timer_clock_sel;
  wire [6:0] flags = {low_power_reset_flag, window_dog_reset_flag, independent_dog_reset_flag,
    software_reset_flag, power_on_reset_flag, pin_reset_flag, brownout_reset_flag};
  wire [31:0] spread_out = {spread_enable, spread_shape_select, 2'h0, modulation_step,
    modulation_period};
  wire [18:0] audio_out = {audio_pll_out_divider, audio_pll_multiplier, audio_pll_in_divider,
    audio_pll_config_valid};
  wire [4:0] tim_out = {timer_clock_prescale_select, apb1_timer_clock_sel, apb2_timer_clock_sel};
  integer n_fail, check_count, cyc;
  rcp_clock_regs u_rcp_clock_regs (.hclk, .hresetn, .power_resetn, .clk_enable, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .low_power_reset_event(ev[6]), .window_dog_reset_event(ev[5]),
    .independent_dog_reset_event(ev[4]), .software_reset_event(ev[3]),
    .power_on_reset_event(ev[2]), .external_reset_pin_event(ev[1]),
    .brownout_reset_event(ev[0]), .slow_rc_clk, .slow_rc_stable, .audio_pll_enable,
    .apb1_prescale, .apb2_prescale, .slow_rc_enable, .slow_rc_ready, .low_power_reset_flag,
    .window_dog_reset_flag, .independent_dog_reset_flag, .software_reset_flag,
    .power_on_reset_flag, .pin_reset_flag, .brownout_reset_flag, .spread_enable,
    .spread_shape_select, .modulation_step, .modulation_period, .audio_pll_out_divider,
    .audio_pll_multiplier, .audio_pll_in_divider, .audio_pll_config_valid,
    .timer_clock_prescale_select, .apb1_timer_clock_sel, .apb2_timer_clock_sel);
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  initial begin
    slow_rc_clk = 1'b0;
    #3;
    forever #37 slow_rc_clk = ~slow_rc_clk;
  end
  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      end_of_test;
    end
  end
  // One single transfer: address phase, then data phase
  task bus(input [31:0] a, input w, input [2:0] s, input [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= s;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task wr(input [31:0] a, input [31:0] d, input [2:0] s);
    bus(a, 1'b1, s, d);
  endtask
  task chk_rd(input [31:0] a, input [31:0] e);
    bus(a, 1'b0, 3'h2, 32'h0);
    `CHK("read", e, q)
  endtask
  task t_reset;
    chk_rd(32'h74, 32'h0e000000);
    chk_rd(32'h80, 32'h00000000);
    chk_rd(32'h84, 32'h24003000);
    chk_rd(32'h8c, 32'h00000000);
    wr(32'h90, 32'hffffffff, 3'h2);
    chk_rd(32'h90, 32'h00000000);
  endtask
  task t_flags;
    integer i;
    reg [31:0] e;
    for (i = 0; i < 7; i = i + 1) begin
      wr(32'h74, 32'h01000000, 3'h2);
      chk_rd(32'h74, 32'h0);
      ev <= 7'h01 << i;
      repeat (4) @(posedge hclk);
      ev <= 7'h00;
      repeat (3) @(posedge hclk);
      e = (32'h1 << (25 + i)) | ((i == 2) ? 32'h02000000 : 32'h0);
      chk_rd(32'h74, e);
      `CHK("flags", e[31:25], flags)
      wr(32'h74, 32'h0, 3'h2);
      chk_rd(32'h74, e);
    end
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    chk_rd(32'h74, 32'h80000000);
  endtask
  task t_slow;
    integer n;
    `CHK("ready off", 1'b0, slow_rc_ready)
    wr(32'h74, 32'h1, 3'h2);
    repeat (8) @(posedge hclk);
    `CHK("enable", 1'b1, slow_rc_enable)
    chk_rd(32'h74, 32'h80000003);
    wr(32'h74, 32'h0, 3'h2);
    n = 0;
    while (slow_rc_ready === 1'b1 && n < 200) begin
      @(posedge hclk);
      n = n + 1;
    end
    `CHK("ready fall", 1'b1, n >= 18 && n <= 42)
    wr(32'h74, 32'h1, 3'h2);
    repeat (8) @(posedge hclk);
    slow_rc_stable <= 1'b0;
    repeat (8) @(posedge hclk);
    `CHK("ready unstable", 1'b0, slow_rc_ready)
    slow_rc_stable <= 1'b1;
    wr(32'h74, 32'h0, 3'h2);
  endtask
  task t_spread;
    wr(32'h80, 32'hffffffff, 3'h2);
    chk_rd(32'h80, 32'hcfffffff);
    `CHK("spread", 32'hcfffffff, spread_out)
    wr(32'h80, 32'h4000a005, 3'h2);
    @(posedge hclk);
    `CHK("spread", {4'h4, 15'h0005, 13'h0005}, spread_out)
    wr(32'h81, 32'h00005a00, 3'h0);
    chk_rd(32'h80, 32'h40005a05);
    wr(32'h82, 32'h80010000, 3'h1);
    chk_rd(32'h80, 32'h80015a05);
  endtask
  task apll(input [2:0] o, input [8:0] m, input [5:0] i, input v);
    reg [31:0] w;
    w = {1'b0, o, 13'h0, m, i};
    wr(32'h84, w, 3'h2);
    chk_rd(32'h84, w | 32'h04000000);
    `CHK("audio", {o, m, i, v}, audio_out)
  endtask
  task t_audio;
    `CHK("audio rst", 19'h26000, audio_out)
    apll(3'h2, 9'h032, 6'h02, 1'b1);
    apll(3'h7, 9'h1b0, 6'h3f, 1'b1);
    apll(3'h1, 9'h064, 6'h04, 1'b0);
    apll(3'h0, 9'h064, 6'h04, 1'b0);
    apll(3'h3, 9'h1b1, 6'h04, 1'b0);
    apll(3'h3, 9'h031, 6'h04, 1'b0);
    apll(3'h3, 9'h064, 6'h01, 1'b0);
    apll(3'h3, 9'h064, 6'h00, 1'b0);
    wr(32'h85, 32'h0000ff00, 3'h0);
    @(posedge hclk);
    `CHK("mul byte", 9'h064, audio_pll_multiplier)
    wr(32'h84, 32'h00003204, 3'h1);
    @(posedge hclk);
    `CHK("mul half", 9'h0c8, audio_pll_multiplier)
    audio_pll_enable <= 1'b1;
    repeat (4) @(posedge hclk);
    wr(32'h84, 32'h50004b09, 3'h2);
    @(posedge hclk);
    `CHK("locked", 18'h2b204, audio_out[18:1])
    audio_pll_enable <= 1'b0;
  endtask
  function [1:0] tsel(input t, input [2:0] p);
    if (p < 3'h4 || (t && p == 3'h4))
      tsel = 2'h0;
    else
      tsel = t ? 2'h2 : 2'h1;
  endfunction
  task t_dck;
    integer t, p;
    wr(32'h8c, 32'hffffffff, 3'h2);
    chk_rd(32'h8c, 32'h01000000);
    for (t = 0; t < 2; t = t + 1) begin
      wr(32'h8c, t << 24, 3'h2);
      for (p = 0; p < 8; p = p + 1) begin
        apb1_prescale <= p;
        apb2_prescale <= 7 - p;
        repeat (2) @(posedge hclk);
        `CHK("timer", {t[0], tsel(t, p), tsel(t, 7 - p)}, tim_out)
      end
    end
  endtask
  task t_freeze;
    clk_enable <= 1'b0;
    ev <= 7'h20;
    repeat (6) @(posedge hclk);
    `CHK("frozen ready", 1'b0, hreadyout)
    ev <= 7'h00;
    repeat (2) @(posedge hclk);
    clk_enable <= 1'b1;
    repeat (4) @(posedge hclk);
    `CHK("frozen flag", 1'b0, window_dog_reset_flag)
  endtask
  initial begin
    n_fail = 0;
    check_count = 0;
    cyc = 0;
    hresetn = 1'b0;
    power_resetn = 1'b0;
    clk_enable = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    slow_rc_stable = 1'b1;
    audio_pll_enable = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    apb1_prescale = 3'h0;
    apb2_prescale = 3'h0;
    ev = 7'h00;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    power_resetn <= 1'b1;
    t_reset;
    t_flags;
    t_slow;
    t_spread;
    t_audio;
    t_dck;
    t_freeze;
    end_of_test;
  end
endmodule
